/* rtl/data_buffer_register_file_access.sv */
`timescale 1ns/100ps
`include "dbrf_map.svh"

// Functional notes
// - One command combines any memory nibble with the selected work row nibble.
// - Work row nibbles are plain data memory, reachable by ordinary reads and writes.
// - Work row pointer: low three bits pick row, upper two bits pick bank.
// - Staging buffer occupies data memory nibbles 0CH to 0FH.
// - Address 05H: timer count read by get only; put does nothing.
// - Address 06H: timer modulo loaded by put only; get does not read it.
// - Addresses 03H and 04H: carrier modulo registers support put and get.
// - Address 40H: program address pointer moves through all four buffer nibbles.
// - Reading the pointer returns zero in its unimplemented top bits.
// - Writing the pointer discards values for its unimplemented top bits.
// - Table read loads the ROM word at the pointer into the buffer.
// - Writes to read-only registers leave every state unchanged.
// - Get from unused peripheral address is undefined; put there does nothing.
// - Unused control register reads are undefined; writes change nothing.
// - Space addresses 00H to 3FH reach control registers in any bank.
// - Space addresses 40H to 7FH reach the matching data memory nibbles.
// - Control space holds 64 nibbles, only 24 implemented.
// - Space read copies the addressed nibble into the window register.
// - Space write copies the window register into the addressed nibble.
module data_buffer_register_file_access (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Instruction sequencer
  input wire logic cmdValid,
  input wire dbrf_pkg::cmd_t cmd,
  output logic cmdAck,
  output logic [3:0] readData,
  output logic [3:0] windowReg,
  output logic [15:0] stagingBuf,
  output logic [4:0] workRowPointer,
  // Peripherals
  input wire logic [7:0] timerCount,
  output dbrf_pkg::periph_t periph,
  output logic [255:0] ctrlRegs,
  // Program memory
  output logic [15:0] romAddr,
  input wire logic [15:0] romWord
);

  // ----------------------------------------
  // State and storage
  // ----------------------------------------
  localparam logic [63:0] ImplMask = `CTRL_IMPL_MASK;
  localparam logic [63:0] RoMask = `CTRL_RO_MASK;

  dbrf_pkg::state_t q, d;
  logic [3:0] dataMem [0:639];
  logic memWe;
  logic [9:0] memWIdx;
  logic [3:0] memWData;
  logic wEn;
  logic [2:0] wBank;
  logic [6:0] wAddr;
  logic [3:0] wData;
  logic [2:0] rowBank;
  logic [6:0] rowAddr;
  logic [3:0] rowVal;
  logic [3:0] memVal;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  // Staging buffer sits at 0CH..0FH of every bank
  function automatic logic inBuf(input logic [6:0] a);
    return (a >= `BUF_FIRST) && (a <= `BUF_LAST);
  endfunction

  // Reads data memory or the staging buffer
  function automatic logic [3:0] memRead(input logic [2:0] b, input logic [6:0] a);
    if (inBuf(a))
    begin
      return q.stagingBuf[{a[1:0], 2'b00} +: 4];
    end
    if (b >= `NUM_BANKS)
    begin
      return `UNUSED_READ;
    end
    return dataMem[{b, a}];
  endfunction

  // Control register read, unused ones give a fixed filler
  function automatic logic [3:0] ctrlRead(input logic [5:0] i);
    return ImplMask[i] ? q.ctrlRegs[{i, 2'b00} +: 4] : `UNUSED_READ;
  endfunction

  function automatic logic ctrlWritable(input logic [5:0] i);
    return ImplMask[i] && !RoMask[i];
  endfunction

  function automatic logic [3:0] aluCalc(input dbrf_pkg::alu_t f, input logic [3:0] a, input logic [3:0] b);
    case (f)
      dbrf_pkg::ALU_ADD: return 4'(a + b);
      dbrf_pkg::ALU_SUB: return 4'(a - b);
      dbrf_pkg::ALU_AND: return a & b;
      dbrf_pkg::ALU_OR: return a | b;
      dbrf_pkg::ALU_XOR: return a ^ b;
      dbrf_pkg::ALU_LOAD: return b;
      default: return a;
    endcase
  endfunction

  // Work row location from the pointer
  assign rowBank = {1'b0, q.workRowPointer[4:3]};
  assign rowAddr = {q.workRowPointer[2:0], cmd.col};
  assign rowVal = memRead(rowBank, rowAddr);
  assign memVal = memRead(cmd.bank, cmd.addr);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.ack = cmdValid;
    wEn = 1'b0;
    wBank = cmd.bank;
    wAddr = cmd.addr;
    wData = cmd.imm[3:0];
    memWe = 1'b0;
    memWIdx = {cmd.bank, cmd.addr};
    memWData = wData;
    if (cmdValid)
    begin
      case (cmd.op)
        dbrf_pkg::OP_MEM_WR:
        begin
          wEn = 1'b1;
        end
        dbrf_pkg::OP_MEM_RD:
        begin
          d.readData = memVal;
        end
        // Work row arithmetic and transfer
        dbrf_pkg::OP_ALU:
        begin
          wEn = 1'b1;
          if (cmd.alu == dbrf_pkg::ALU_STORE)
          begin
            wData = rowVal;
          end
          else
          begin
            wBank = rowBank;
            wAddr = rowAddr;
            wData = aluCalc(cmd.alu, rowVal, memVal);
          end
        end
        // Buffer to peripheral
        dbrf_pkg::OP_PUT:
        begin
          case (cmd.periph)
            `PA_CARRIER_LOW: d.periph.carrierLow = q.stagingBuf[7:0];
            `PA_CARRIER_HIGH: d.periph.carrierHigh = q.stagingBuf[7:0];
            `PA_TIMER_MODULO: d.periph.timerModulo = q.stagingBuf[7:0];
            `PA_ADDR_PTR: d.periph.addrPtr = q.stagingBuf & `PTR_KEEP_MASK;
            default: d.periph = q.periph;
          endcase
        end
        // Peripheral to buffer
        dbrf_pkg::OP_GET:
        begin
          case (cmd.periph)
            `PA_CARRIER_LOW: d.stagingBuf[7:0] = q.periph.carrierLow;
            `PA_CARRIER_HIGH: d.stagingBuf[7:0] = q.periph.carrierHigh;
            `PA_TIMER_COUNT: d.stagingBuf[7:0] = timerCount;
            `PA_ADDR_PTR: d.stagingBuf = q.periph.addrPtr & `PTR_KEEP_MASK;
            default: d.stagingBuf = q.stagingBuf;
          endcase
        end
        // Space read and write through the window
        dbrf_pkg::OP_SPACE_RD:
        begin
          if (!cmd.addr[6])
          begin
            d.windowReg = ctrlRead(cmd.addr[5:0]);
          end
          else
          begin
            d.windowReg = memVal;
          end
        end
        dbrf_pkg::OP_SPACE_WR:
        begin
          if (!cmd.addr[6])
          begin
            if (ctrlWritable(cmd.addr[5:0]))
            begin
              d.ctrlRegs[{cmd.addr[5:0], 2'b00} +: 4] = q.windowReg;
            end
          end
          else
          begin
            wEn = 1'b1;
            wData = q.windowReg;
          end
        end
        // Table read from program memory
        dbrf_pkg::OP_TABLE_RD:
        begin
          d.stagingBuf = romWord;
        end
        dbrf_pkg::OP_SET_WR:
        begin
          d.windowReg = cmd.imm[3:0];
        end
        dbrf_pkg::OP_SET_ROW:
        begin
          d.workRowPointer = cmd.imm;
        end
        default:
        begin
          d.readData = q.readData;
        end
      endcase
    end
    // Route one nibble write to buffer or array
    if (wEn)
    begin
      if (inBuf(wAddr))
      begin
        d.stagingBuf[{wAddr[1:0], 2'b00} +: 4] = wData;
      end
      else if (wBank < `NUM_BANKS)
      begin
        memWe = 1'b1;
        memWIdx = {wBank, wAddr};
        memWData = wData;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Data memory array, not cleared by reset
  always_ff @(posedge clock)
  begin
    if (memWe)
    begin
      dataMem[memWIdx] <= memWData;
    end
  end

  // Outputs straight from flops
  assign cmdAck = q.ack;
  assign readData = q.readData;
  assign windowReg = q.windowReg;
  assign stagingBuf = q.stagingBuf;
  assign workRowPointer = q.workRowPointer;
  assign periph = q.periph;
  assign ctrlRegs = q.ctrlRegs;
  assign romAddr = q.periph.addrPtr;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence putAt(logic [7:0] pa);
    cmdValid && cmd.op == dbrf_pkg::OP_PUT && cmd.periph == pa;
  endsequence

  sequence getAt(logic [7:0] pa);
    cmdValid && cmd.op == dbrf_pkg::OP_GET && cmd.periph == pa;
  endsequence

  // Command of one kind, any operands
  sequence opIs(dbrf_pkg::op_t o);
    cmdValid && cmd.op == o;
  endsequence

  put_modulo_a: assert property (putAt(`PA_TIMER_MODULO) |=> periph.timerModulo == $past(stagingBuf[7:0]))
    else $error("timer modulo not loaded by put");
  get_count_a: assert property (getAt(`PA_TIMER_COUNT) |=> stagingBuf[7:0] == $past(timerCount))
    else $error("timer count not read by get");
  put_count_none_a: assert property (putAt(`PA_TIMER_COUNT) |=> $stable(periph) && $stable(stagingBuf))
    else $error("put to timer count changed state");
  carrier_trip_a: assert property (putAt(`PA_CARRIER_HIGH) ##1 getAt(`PA_CARRIER_HIGH)
    |=> stagingBuf[7:0] == $past(stagingBuf[7:0], 2))
    else $error("carrier high modulo round trip lost");
  ptr_top_zero_a: assert property (getAt(`PA_ADDR_PTR) |=> stagingBuf[15:14] == 2'b00)
    else $error("pointer top bits not zero on get");
  ptr_write_a: assert property (putAt(`PA_ADDR_PTR)
    |=> romAddr == ($past(stagingBuf) & `PTR_KEEP_MASK))
    else $error("pointer put wrong");
  table_read_a: assert property (cmdValid && cmd.op == dbrf_pkg::OP_TABLE_RD
    |=> stagingBuf == $past(romWord))
    else $error("table read did not load buffer");
  space_ro_a: assert property (cmdValid && cmd.op == dbrf_pkg::OP_SPACE_WR && !cmd.addr[6]
    && !ctrlWritable(cmd.addr[5:0]) |=> $stable(ctrlRegs))
    else $error("protected control nibble changed");
  space_trip_a: assert property (cmdValid && cmd.op == dbrf_pkg::OP_SPACE_WR && cmd.addr[6]
    ##1 cmdValid && cmd.op == dbrf_pkg::OP_SPACE_RD && cmd.addr == $past(cmd.addr) && cmd.bank == $past(cmd.bank)
    |=> windowReg == $past(windowReg, 2))
    else $error("space write then read mismatch");

  // Acknowledge follows every command
  ack_follow_a: assert property (cmdValid |=> cmdAck)
    else $error("command not acknowledged");

  // Row pointer load
  row_select_a: assert property (opIs(dbrf_pkg::OP_SET_ROW) |=> workRowPointer == $past(cmd.imm))
    else $error("work row pointer not loaded");

  // Memory write then read back
  mem_back_a: assert property (cmdValid && cmd.op == dbrf_pkg::OP_MEM_WR && cmd.bank < `NUM_BANKS
    ##1 cmdValid && cmd.op == dbrf_pkg::OP_MEM_RD && cmd.addr == $past(cmd.addr) && cmd.bank == $past(cmd.bank)
    |=> readData == $past(cmd.imm[3:0], 2))
    else $error("memory nibble read back wrong");

  // Put to a read-only or unused address leaves the peripheral registers
  put_unused_a: assert property (cmdValid && cmd.op == dbrf_pkg::OP_PUT
    && !(cmd.periph inside {`PA_CARRIER_LOW, `PA_CARRIER_HIGH, `PA_TIMER_MODULO, `PA_ADDR_PTR}) |=> $stable(periph))
    else $error("put to unused address changed peripheral");

  // Get from a write-only or unused address leaves the buffer
  get_unused_a: assert property (cmdValid && cmd.op == dbrf_pkg::OP_GET
    && !(cmd.periph inside {`PA_CARRIER_LOW, `PA_CARRIER_HIGH, `PA_TIMER_COUNT, `PA_ADDR_PTR}) |=> $stable(stagingBuf))
    else $error("get from unused address changed buffer");

  // Unused control nibble reads back the filler
  space_read_op_unused_a: assert property (cmdValid && cmd.op == dbrf_pkg::OP_SPACE_RD && !cmd.addr[6]
    && !ImplMask[cmd.addr[5:0]] |=> windowReg == `UNUSED_READ)
    else $error("unused control nibble read wrong");

endmodule

/* common/dbrf_map.svh */
`ifndef DBRF_MAP_SVH
`define DBRF_MAP_SVH

// ----------------------------------------
// Data memory layout
// ----------------------------------------
`define BUF_FIRST 7'h0C
`define BUF_LAST 7'h0F
`define NUM_BANKS 3'h5

// ----------------------------------------
// Peripheral addresses for put and get
// ----------------------------------------
`define PA_CARRIER_LOW 8'h03
`define PA_CARRIER_HIGH 8'h04
`define PA_TIMER_COUNT 8'h05
`define PA_TIMER_MODULO 8'h06
`define PA_ADDR_PTR 8'h40

// ----------------------------------------
// Field masks and reset values
// ----------------------------------------
`define PTR_KEEP_MASK 16'h3fff
`define CTRL_IMPL_MASK 64'h00ff_00ff_00ff_0000
`define CTRL_RO_MASK 64'h0000_0003_0000_0000
`define RESET_NIBBLE 4'h0
`define RESET_WORD 16'h0000
`define UNUSED_READ 4'h0

`endif

/* common/dbrf_pkg.sv */
package dbrf_pkg;

  // ----------------------------------------
  // Commands from the instruction sequencer
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_MEM_WR = 4'h1,
    OP_MEM_RD = 4'h2,
    OP_ALU = 4'h3,
    OP_PUT = 4'h4,
    OP_GET = 4'h5,
    OP_SPACE_RD = 4'h6,
    OP_SPACE_WR = 4'h7,
    OP_TABLE_RD = 4'h8,
    OP_SET_WR = 4'h9,
    OP_SET_ROW = 4'ha
  } op_t;

  // Operation between memory nibble and work row nibble
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_AND = 3'h2,
    ALU_OR = 3'h3,
    ALU_XOR = 3'h4,
    ALU_LOAD = 3'h5,
    ALU_STORE = 3'h6
  } alu_t;

  typedef struct packed {
    op_t op;
    alu_t alu;
    logic [2:0] bank;
    logic [6:0] addr;
    logic [3:0] col;
    logic [7:0] periph;
    logic [4:0] imm;
  } cmd_t;

  // ----------------------------------------
  // Peripheral registers and block state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] carrierLow;
    logic [7:0] carrierHigh;
    logic [7:0] timerModulo;
    logic [15:0] addrPtr;
  } periph_t;

  typedef struct packed {
    logic [4:0] workRowPointer;
    logic [3:0] windowReg;
    logic [15:0] stagingBuf;
    periph_t periph;
    logic [255:0] ctrlRegs;
    logic [3:0] readData;
    logic ack;
  } state_t;

endpackage

/* bench/periph_model.sv */
`timescale 1ns/100ps

// ----------------------------------------
// Timer and program memory stand-in
// ----------------------------------------
module periph_model #(
  parameter logic [7:0] COUNT = 8'hc3
) (
  // Program memory
  input wire logic [15:0] romAddr,
  output logic [15:0] romWord,
  // Timer
  output logic [7:0] timerCount
);
  // Frozen count keeps the expected get value simple
  assign timerCount = COUNT;
  // Word pattern differs from its own address
  assign romWord = {romAddr[7:0] ^ 8'ha5, romAddr[15:8]};
endmodule

/* bench/tb_data_buffer_register_file_access.sv */
`timescale 1ns/100ps

module tb_data_buffer_register_file_access;
  logic clock;
  logic resetn;
  logic cmdValid;
  dbrf_pkg::cmd_t cmd;
  logic cmdAck;
  logic [3:0] readData;
  logic [3:0] windowReg;
  logic [15:0] stagingBuf;
  logic [4:0] workRowPointer;
  logic [7:0] timerCount;
  dbrf_pkg::periph_t periph;
  logic [255:0] ctrlRegs;
  logic [15:0] romAddr;
  logic [15:0] romWord;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  data_buffer_register_file_access uut (.clock(clock), .resetn(resetn), .cmdValid(cmdValid), .cmd(cmd),
    .cmdAck(cmdAck), .readData(readData), .windowReg(windowReg), .stagingBuf(stagingBuf),
    .workRowPointer(workRowPointer), .timerCount(timerCount), .periph(periph), .ctrlRegs(ctrlRegs),
    .romAddr(romAddr), .romWord(romWord));
  periph_model far (.romAddr(romAddr), .romWord(romWord), .timerCount(timerCount));

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 500)
    begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One command, held until its edge, then ack checked
  task automatic go(input dbrf_pkg::op_t op, input logic [7:0] a, input logic [4:0] v,
    input logic [2:0] bk = 3'h0, input logic [3:0] col = 4'h0, input dbrf_pkg::alu_t al = dbrf_pkg::ALU_ADD);
    cmdValid = 1'b1;
    cmd = '{op, al, bk, a[6:0], col, a, v};
    @(posedge clock);
    #1;
    chk("cmdAck", 64'h1, {63'h0, cmdAck});
  endtask

  // Fill the four buffer nibbles
  task automatic fill(input logic [15:0] w);
    for (int i = 0; i < 4; i++)
      go(dbrf_pkg::OP_MEM_WR, 8'h0c + 8'(i), {1'b0, w[4*i +: 4]});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_put();
    fill(16'h4321);
    chk("stagingBuf", 64'h4321, stagingBuf);
    go(dbrf_pkg::OP_MEM_RD, 8'h0f, 5'h00);
    chk("readData", 64'h4, readData);
    go(dbrf_pkg::OP_PUT, 8'h03, 5'h00);
    go(dbrf_pkg::OP_PUT, 8'h04, 5'h00);
    go(dbrf_pkg::OP_PUT, 8'h06, 5'h00);
    go(dbrf_pkg::OP_PUT, 8'h05, 5'h00);
    go(dbrf_pkg::OP_PUT, 8'h07, 5'h00);
    chk("periph", 64'h21_2121_0000, periph);
  endtask

  task automatic t_get();
    go(dbrf_pkg::OP_GET, 8'h06, 5'h00);
    chk("stagingBuf", 64'h4321, stagingBuf);
    go(dbrf_pkg::OP_GET, 8'h05, 5'h00);
    chk("stagingBuf", 64'h43c3, stagingBuf);
    go(dbrf_pkg::OP_GET, 8'h07, 5'h00);
    chk("stagingBuf", 64'h43c3, stagingBuf);
    go(dbrf_pkg::OP_GET, 8'h04, 5'h00);
    chk("stagingBuf", 64'h4321, stagingBuf);
    go(dbrf_pkg::OP_PUT, 8'h04, 5'h00);
    go(dbrf_pkg::OP_GET, 8'h04, 5'h00);
    chk("stagingBuf", 64'h4321, stagingBuf);
  endtask

  task automatic t_pointer();
    fill(16'hffff);
    go(dbrf_pkg::OP_PUT, 8'h40, 5'h00);
    chk("addrPtr", 64'h3fff, periph.addrPtr);
    chk("romAddr", 64'h3fff, romAddr);
    go(dbrf_pkg::OP_MEM_WR, 8'h0c, 5'h00);
    go(dbrf_pkg::OP_GET, 8'h40, 5'h00);
    chk("stagingBuf", 64'h3fff, stagingBuf);
    go(dbrf_pkg::OP_TABLE_RD, 8'h00, 5'h00);
    chk("stagingBuf", 64'h5a3f, stagingBuf);
  endtask

  task automatic t_space();
    go(dbrf_pkg::OP_SET_WR, 8'h00, 5'h05);
    go(dbrf_pkg::OP_SPACE_WR, 8'h10, 5'h00, 3'h3);
    go(dbrf_pkg::OP_SPACE_WR, 8'h20, 5'h00);
    go(dbrf_pkg::OP_SPACE_WR, 8'h00, 5'h00);
    chk("ctrlLow", 64'h0, ctrlRegs[63:0]);
    chk("ctrlMid", 64'h5, ctrlRegs[127:64]);
    chk("ctrlRo", 64'h0, ctrlRegs[191:128]);
    go(dbrf_pkg::OP_SPACE_WR, 8'h45, 5'h00, 3'h1);
    go(dbrf_pkg::OP_SPACE_RD, 8'h45, 5'h00, 3'h1);
    chk("windowReg", 64'h5, windowReg);
    go(dbrf_pkg::OP_SET_WR, 8'h00, 5'h09);
    go(dbrf_pkg::OP_MEM_RD, 8'h45, 5'h00, 3'h1);
    chk("readData", 64'h5, readData);
    go(dbrf_pkg::OP_SPACE_RD, 8'h10, 5'h00, 3'h0);
    chk("windowReg", 64'h5, windowReg);
    go(dbrf_pkg::OP_SPACE_RD, 8'h00, 5'h00);
    chk("windowReg", 64'h0, windowReg);
  endtask

  task automatic t_alu();
    go(dbrf_pkg::OP_SET_ROW, 8'h00, 5'h0a);
    chk("workRowPointer", 64'h0a, workRowPointer);
    go(dbrf_pkg::OP_MEM_WR, 8'h23, 5'h03, 3'h1);
    go(dbrf_pkg::OP_MEM_WR, 8'h50, 5'h04, 3'h0);
    go(dbrf_pkg::OP_ALU, 8'h50, 5'h00, 3'h0, 4'h3);
    go(dbrf_pkg::OP_MEM_RD, 8'h23, 5'h00, 3'h1);
    chk("readData", 64'h7, readData);
    go(dbrf_pkg::OP_ALU, 8'h51, 5'h00, 3'h0, 4'h3, dbrf_pkg::ALU_STORE);
    go(dbrf_pkg::OP_MEM_RD, 8'h51, 5'h00, 3'h0);
    chk("readData", 64'h7, readData);
    go(dbrf_pkg::OP_ALU, 8'h50, 5'h00, 3'h0, 4'h3, dbrf_pkg::ALU_SUB);
    go(dbrf_pkg::OP_MEM_RD, 8'h23, 5'h00, 3'h1);
    chk("readData", 64'h3, readData);
    go(dbrf_pkg::OP_ALU, 8'h50, 5'h00, 3'h0, 4'h3, dbrf_pkg::ALU_XOR);
    go(dbrf_pkg::OP_MEM_RD, 8'h23, 5'h00, 3'h1);
    chk("readData", 64'h7, readData);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    resetn = 1'b0;
    cmdValid = 1'b0;
    cmd = '0;
    repeat (10) @(posedge clock);
    #1;
    resetn = 1'b1;
    chk("stagingBuf", 64'h0, stagingBuf);
    chk("periph", 64'h0, periph);
    t_put();
    t_get();
    t_pointer();
    t_space();
    t_alu();
    cmdValid = 1'b0;
    summarize();
  end
endmodule
